// ### verilog/sbd_core.sv
// Subtract-with-borrow and decrement-skip datapath with APB register access
//
// Operation
// - Subtract-borrow-to-memory computes accumulator minus operand minus inverted carry.
// - Its difference goes back to the addressed byte; accumulator keeps its value.
// - A negative subtraction result clears carry to zero, meaning borrow.
// - A zero or positive subtraction result sets carry to one, meaning no borrow.
// - The subtraction updates overflow, zero, half-byte carry, carry, sign and zero-chain.
// - Decrement-skip subtracts one from the addressed byte and stores it back there.
// - A decremented value of zero skips the next instruction without executing it.
// - A skip inserts one dummy cycle, so the instruction takes two cycles.
// - A nonzero decremented value continues at once with no extra cycle.
// - Accumulator variant puts the decremented value in the accumulator, memory untouched.
// - Accumulator variant also skips when its decremented value is zero.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps

// Register map, one 32-bit word each, unused upper bits read zero:
//   control   op select in the low two bits, start strobe at the go bit
//   acc       working accumulator, low byte
//   addr      data memory pointer, low nibble
//   flags     carry, half-byte carry, zero, signed range, sign compare, zero chain
//   mem       the data memory byte at the pointer
//   status    busy, last skipped, dummy cycle, cycles of the last instruction
// Hazards for software:
//   every write while busy is refused with an error and has no effect
//   writes to status and to unmapped offsets are refused the same way
//   reads are refused only at unmapped offsets, which read zero

module sbd_core (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Execution status
   output logic busy,
   output logic skip_taken,
   output logic dummy_cycle
);

   // ****************************************
   // State record
   // ****************************************
   typedef struct packed {
      sbd_pkg::sbd_state_t st;
      sbd_pkg::sbd_op_t op;
      logic [7:0] acc;
      logic [5:0] flags;
      logic [3:0] addr;
      logic [15:0][7:0] mem;
      logic last_skip;
      logic [1:0] last_cycles;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic busy;
      logic skip_taken;
      logic dummy_cycle;
   } sbd_regs_t;

   sbd_regs_t r;
   sbd_regs_t next_r;

   // ****************************************
   // Datapath results
   // ****************************************
   logic [7:0] operand;
   logic borrow_in;
   logic [8:0] diff9;
   logic [4:0] diff_low;
   logic [7:0] diff;
   logic [7:0] dec_val;
   logic dec_zero;
   logic sub_range_exceeded;
   logic [5:0] sub_flags;

   // Data memory: sixteen bytes held in the state record, read through
   // the pointer; a bus write and an instruction never meet in one cycle,
   // since writes are refused while busy.
   // Addressed data memory byte
   assign operand = r.mem[r.addr];

   // Borrow into the subtraction is the inverted carry
   assign borrow_in = ~r.flags[sbd_pkg::FLG_C];

   // Nine-bit difference so the top bit shows a borrow out
   assign diff9 = {1'b0, r.acc} - {1'b0, operand} - {8'h00, borrow_in};
   assign diff = diff9[7:0];

   // Low nibble difference gives the half-byte borrow
   assign diff_low = {1'b0, r.acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, borrow_in};

   // Signed overflow: operands of unlike sign and result sign differs from minuend
   assign sub_range_exceeded = (r.acc[7] ^ operand[7]) & (r.acc[7] ^ diff[7]);

   // Decrement wraps: a zero byte becomes all ones and does not skip
   // Decrement of the addressed byte and its zero test
   assign dec_val = operand - sbd_pkg::DEC_STEP;
   assign dec_zero = (dec_val == 8'h00);

   // Flag meanings after a subtraction:
   //   carry set means no borrow out of bit 7
   //   half-byte carry set means no borrow out of bit 3
   //   signed range exceeded when the signed difference does not fit
   //   sign compare is the true sign of the difference
   //   zero chain stays set only while every result in a chain is zero
   // The decrement instructions leave every flag alone.
   // Flag set after the subtraction
   always_comb begin
      sub_flags = r.flags;
      sub_flags[sbd_pkg::FLG_C] = ~diff9[8];
      sub_flags[sbd_pkg::FLG_HALF_BYTE_CARRY] = ~diff_low[4];
      sub_flags[sbd_pkg::FLG_Z] = (diff == 8'h00);
      sub_flags[sbd_pkg::FLG_SIGNED_RANGE_EXCEEDED] = sub_range_exceeded;
      sub_flags[sbd_pkg::FLG_SIGN_COMPARE] = sub_range_exceeded ^ diff[7];
      sub_flags[sbd_pkg::FLG_ZERO_ACROSS_OPS] =
         (diff == 8'h00) & r.flags[sbd_pkg::FLG_ZERO_ACROSS_OPS];
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic setup_ph;
   logic access_done;
   logic addr_known;
   logic writable;
   logic [31:0] rd_val;

   // Timing of one transfer, no wait states:
   //   setup edge: answer, error and read data are registered
   //   access cycle: pready stands high for exactly this cycle
   //   completing edge: a write lands, the answer returns to zero
   // Deciding the error at setup keeps pslverr a plain flip-flop output
   // and lets a refused write be dropped at the completing edge.
   // Setup cycle of a transfer and the completing edge of its access phase
   assign setup_ph = psel & ~penable;
   assign access_done = psel & penable & r.pready;

   // Only the six word-aligned offsets are mapped; any other byte address
   // answers with an error, which keeps stray partial addresses harmless.
   // Map check
   always_comb begin
      case (paddr)
         sbd_pkg::REG_CTRL,
         sbd_pkg::REG_ACC,
         sbd_pkg::REG_ADDR,
         sbd_pkg::REG_FLAGS,
         sbd_pkg::REG_MEM,
         sbd_pkg::REG_STAT: begin
            addr_known = 1'b1;
         end
         default: begin
            addr_known = 1'b0;
         end
      endcase
   end

   // Writes are refused while an instruction runs and to the status word
   assign writable = ~r.busy & (paddr != sbd_pkg::REG_STAT);

   // Read data is chosen at setup from the current register values;
   // a read of mem returns the byte at the current pointer.
   // Read multiplexer, narrow fields sit low and upper bits read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr)
         sbd_pkg::REG_CTRL: begin
            rd_val[sbd_pkg::CTRL_OP_LSB +: 2] = r.op;
         end
         sbd_pkg::REG_ACC: begin
            rd_val[7:0] = r.acc;
         end
         sbd_pkg::REG_ADDR: begin
            rd_val[3:0] = r.addr;
         end
         sbd_pkg::REG_FLAGS: begin
            rd_val[5:0] = r.flags;
         end
         sbd_pkg::REG_MEM: begin
            rd_val[7:0] = operand;
         end
         sbd_pkg::REG_STAT: begin
            rd_val[sbd_pkg::STAT_BUSY] = r.busy;
            rd_val[sbd_pkg::STAT_SKIP] = r.last_skip;
            rd_val[sbd_pkg::STAT_DUMMY] = r.dummy_cycle;
            rd_val[sbd_pkg::STAT_CYC_LSB +: 2] = r.last_cycles;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // ****************************************
   // Next state
   // ****************************************
   // Pulses default to zero; every other field holds unless changed below
   always_comb begin
      next_r = r;
      next_r.skip_taken = 1'b0;

      // Answer is prepared in the setup cycle and held for one access cycle
      if (setup_ph) begin
         next_r.pready = 1'b1;
         next_r.prdata = pwrite ? 32'h0000_0000 : rd_val;
         next_r.pslverr = ~addr_known | (pwrite & ~writable);
      end else if (access_done) begin
         next_r.pready = 1'b0;
         next_r.pslverr = 1'b0;
         next_r.prdata = 32'h0000_0000;
      end

      // The pointer in force at the completing edge selects the memory byte,
      // so a pointer write followed by a memory write behaves as expected.
      // Register writes land only at the completing edge of an accepted access
      if (access_done & pwrite & ~r.pslverr) begin
         case (paddr)
            sbd_pkg::REG_CTRL: begin
               next_r.op = sbd_pkg::sbd_op_t'(pwdata[sbd_pkg::CTRL_OP_LSB +: 2]);
               if (pwdata[sbd_pkg::CTRL_GO_BIT]) begin
                  next_r.st = sbd_pkg::ST_EXEC;
                  next_r.busy = 1'b1;
               end
            end
            sbd_pkg::REG_ACC: begin
               next_r.acc = pwdata[7:0];
            end
            sbd_pkg::REG_ADDR: begin
               next_r.addr = pwdata[3:0];
            end
            sbd_pkg::REG_FLAGS: begin
               next_r.flags = pwdata[5:0];
            end
            sbd_pkg::REG_MEM: begin
               next_r.mem[r.addr] = pwdata[7:0];
            end
            default: begin
               next_r.op = r.op;
            end
         endcase
      end

      // Instruction sequencer, one pclk per instruction cycle
      // Timeline after the edge E that lands a go write:
      //   cycle after E: busy high, the instruction waits to execute
      //   edge E+1: results stored; busy falls unless the result skips
      //   skip: skip_taken and dummy_cycle stand one cycle, busy falls at E+2
      // The dummy cycle stands in for the skipped instruction, so a
      // skipping decrement always takes two instruction cycles.
      case (r.st)
         sbd_pkg::ST_IDLE: begin
            next_r.dummy_cycle = 1'b0;
         end
         sbd_pkg::ST_EXEC: begin
            next_r.last_skip = 1'b0;
            next_r.last_cycles = sbd_pkg::CYC_PLAIN;
            next_r.st = sbd_pkg::ST_IDLE;
            next_r.busy = 1'b0;
            case (r.op)
               sbd_pkg::OP_SUB_BORROW_TO_MEM: begin
                  next_r.mem[r.addr] = diff;
                  next_r.flags = sub_flags;
               end
               sbd_pkg::OP_DEC_SKIP_ZERO: begin
                  next_r.mem[r.addr] = dec_val;
               end
               sbd_pkg::OP_DEC_SKIP_ZERO_TO_ACC: begin
                  next_r.acc = dec_val;
               end
               default: begin
                  next_r.last_cycles = sbd_pkg::CYC_PLAIN;
               end
            endcase
            // Zero result of either decrement skips with a dummy cycle
            if ((r.op == sbd_pkg::OP_DEC_SKIP_ZERO ||
                 r.op == sbd_pkg::OP_DEC_SKIP_ZERO_TO_ACC) && dec_zero) begin
               next_r.st = sbd_pkg::ST_DUMMY;
               next_r.busy = 1'b1;
               next_r.last_skip = 1'b1;
               next_r.skip_taken = 1'b1;
               next_r.dummy_cycle = 1'b1;
               next_r.last_cycles = sbd_pkg::CYC_SKIP;
            end else begin
               next_r.dummy_cycle = 1'b0;
            end
         end
         sbd_pkg::ST_DUMMY: begin
            // Dummy cycle stands in for the skipped instruction
            next_r.st = sbd_pkg::ST_IDLE;
            next_r.busy = 1'b0;
            next_r.dummy_cycle = 1'b0;
         end
         default: begin
            next_r.st = sbd_pkg::ST_IDLE;
            next_r.busy = 1'b0;
            next_r.dummy_cycle = 1'b0;
         end
      endcase
   end

   // ****************************************
   // State register
   // ****************************************
   // Reset is asynchronous in assertion; release is taken to be clean
   // with respect to pclk, as the bus reset of the system provides it.
   // Every field returns to its idle value, memory included.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.st <= sbd_pkg::ST_IDLE;
         r.op <= sbd_pkg::OP_SUB_BORROW_TO_MEM;
         r.acc <= sbd_pkg::ACC_RST;
         r.flags <= sbd_pkg::FLAGS_RST;
         r.addr <= 4'h0;
         r.mem <= {sbd_pkg::MEM_DEPTH{sbd_pkg::MEM_RST}};
         r.last_skip <= 1'b0;
         r.last_cycles <= 2'h0;
         r.prdata <= 32'h0000_0000;
         r.pready <= 1'b0;
         r.pslverr <= 1'b0;
         r.busy <= 1'b0;
         r.skip_taken <= 1'b0;
         r.dummy_cycle <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state record
   // Each output is a record field, so it comes straight from a flip-flop
   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign busy = r.busy;
   assign skip_taken = r.skip_taken;
   assign dummy_cycle = r.dummy_cycle;

endmodule

// ### verilog/sbd_pkg.sv
// Constants and types for the subtract-with-borrow and decrement-skip datapath
package sbd_pkg;
   // ****************************************
   // Register byte offsets on the APB slave
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_ADDR = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0c;
   localparam logic [7:0] REG_MEM = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_GO_BIT = 8;
   localparam int FLG_C = 0;
   localparam int FLG_HALF_BYTE_CARRY = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_SIGNED_RANGE_EXCEEDED = 3;
   localparam int FLG_SIGN_COMPARE = 4;
   localparam int FLG_ZERO_ACROSS_OPS = 5;
   localparam int STAT_BUSY = 0;
   localparam int STAT_SKIP = 1;
   localparam int STAT_DUMMY = 2;
   localparam int STAT_CYC_LSB = 4;

   // ****************************************
   // Sizes, reset values and cycle counts
   // ****************************************
   localparam int MEM_DEPTH = 16;
   localparam int MEM_AW = 4;
   localparam int FLAG_W = 6;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   localparam logic [7:0] MEM_RST = 8'h00;
   localparam logic [7:0] DEC_STEP = 8'h01;
   localparam logic [1:0] CYC_PLAIN = 2'h1;
   localparam logic [1:0] CYC_SKIP = 2'h2;

   // Instruction selector written to the control register
   typedef enum logic [1:0] {
      OP_SUB_BORROW_TO_MEM = 2'b00,
      OP_DEC_SKIP_ZERO = 2'b01,
      OP_DEC_SKIP_ZERO_TO_ACC = 2'b10,
      OP_NONE = 2'b11
   } sbd_op_t;

   // Execution sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_DUMMY = 2'b10
   } sbd_state_t;
endpackage

// ### testbench/sbd_checker.sv
// Checker for bus timing and execution timing of the datapath
`timescale 1ns/100ps
module sbd_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus and status
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy,
   input wire logic skip_taken,
   input wire logic dummy_cycle
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   unmapped_a: assert property (psel && !penable && paddr > sbd_pkg::REG_STAT
      |=> pslverr && prdata == 32'h0) else $error("unmapped access accepted");
   busy_refuse_a: assert property (psel && !penable && pwrite && busy |=> pslverr)
      else $error("write while busy accepted");
   go_start_a: assert property (psel && penable && pready && pwrite
      && paddr == sbd_pkg::REG_CTRL && pwdata[sbd_pkg::CTRL_GO_BIT] && !pslverr |=> busy)
      else $error("no start");
   run_length_a: assert property ($rose(busy) |=> busy == skip_taken)
      else $error("busy length wrong");
   dummy_pair_a: assert property (dummy_cycle == skip_taken)
      else $error("dummy and skip differ");
   skip_end_a: assert property (skip_taken |-> busy ##1 !busy && !skip_taken)
      else $error("skip not two cycles");
   skip_cause_a: assert property (skip_taken |-> $past(busy) && !$past(skip_taken))
      else $error("skip without instruction");
endmodule

bind sbd_core sbd_checker i_sbd_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .busy(busy), .skip_taken(skip_taken),
   .dummy_cycle(dummy_cycle));

// ### testbench/tb.sv
// Self-checking bench for the subtract and decrement-skip datapath
`timescale 1ns/100ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat, nb, ns, nd;
   logic pready, pslverr, busy, skip_taken, dummy_cycle, rerr;
   int fail_count = 0;
   int comparisons = 0;

   // Clock at 25 MHz
   always #20 pclk = ~pclk;

   sbd_core i_sbd_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle));

   // ****************************************
   // Bus tasks and comparison
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One transfer entered just after an edge; rel frees the bus and lets an edge pass
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit rel);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      if (rel) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b1);
      chk(rdat, e);
   endtask

   // Start an instruction, then count busy and skip cycles
   task automatic go(input logic [1:0] op);
      nb = 32'h0;
      ns = 32'h0;
      nd = 32'h0;
      apb(1'b1, sbd_pkg::REG_CTRL, {23'h0, 1'b1, 6'h0, op}, 1'b0);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) begin
         @(posedge pclk);
         nb += {31'h0, busy};
         ns += {31'h0, skip_taken};
         nd += {31'h0, dummy_cycle};
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_sub(input logic [7:0] a, input logic [7:0] m, input logic ci, input logic cz);
      logic [8:0] f;
      logic [4:0] h;
      logic rng;
      logic [31:0] fl;
      f = {1'b0, a} - {1'b0, m} - {8'h0, !ci};
      h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, !ci};
      rng = (a[7] != m[7]) && (f[7] != a[7]);
      fl = {26'h0, (f[7:0] == 8'h0) && cz, rng ^ f[7], rng, f[7:0] == 8'h0, !h[4], !f[8]};
      wr(sbd_pkg::REG_ACC, {24'h0, a});
      wr(sbd_pkg::REG_ADDR, 32'h7);
      wr(sbd_pkg::REG_MEM, {24'h0, m});
      wr(sbd_pkg::REG_FLAGS, {26'h0, cz, 4'h0, ci});
      go(2'h0);
      rd(sbd_pkg::REG_MEM, {24'h0, f[7:0]});
      rd(sbd_pkg::REG_ACC, {24'h0, a});
      rd(sbd_pkg::REG_FLAGS, fl);
   endtask

   task automatic t_dec(input logic [1:0] op, input logic [7:0] m);
      logic [7:0] r;
      r = m - 8'h01;
      wr(sbd_pkg::REG_ADDR, 32'h5);
      wr(sbd_pkg::REG_MEM, {24'h0, m});
      wr(sbd_pkg::REG_ACC, 32'h5a);
      wr(sbd_pkg::REG_FLAGS, 32'h2b);
      go(op);
      chk(nb, (r == 8'h0) ? 32'h2 : 32'h1);
      chk(ns, {31'h0, r == 8'h0});
      chk(nd, {31'h0, r == 8'h0});
      rd(sbd_pkg::REG_MEM, {24'h0, (op == 2'h1) ? r : m});
      rd(sbd_pkg::REG_ACC, {24'h0, (op == 2'h1) ? 8'h5a : r});
      rd(sbd_pkg::REG_FLAGS, 32'h2b);
      rd(sbd_pkg::REG_STAT, (r == 8'h0) ? 32'h22 : 32'h10);
   endtask

   // Writes while busy and to the status word are refused, and so is a read of an unmapped place
   task automatic t_refuse();
      wr(sbd_pkg::REG_ACC, 32'h11);
      apb(1'b1, sbd_pkg::REG_CTRL, 32'h103, 1'b0);
      apb(1'b1, sbd_pkg::REG_ACC, 32'h22, 1'b1);
      chk({31'h0, rerr}, 32'h1);
      rd(sbd_pkg::REG_ACC, 32'h11);
      rd(sbd_pkg::REG_CTRL, 32'h3);
      wr(sbd_pkg::REG_STAT, 32'h3);
      chk({31'h0, rerr}, 32'h1);
      rd(8'h40, 32'h0);
      chk({31'h0, rerr}, 32'h1);
   endtask

   task automatic give_verdict();
      if (fail_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge pclk);
      fail_count++;
      give_verdict();
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++) begin
         rd(8'(i * 4), 32'h0);
      end
      t_sub(8'h10, 8'h20, 1'b1, 1'b1);
      t_sub(8'h30, 8'h2f, 1'b0, 1'b1);
      t_sub(8'h80, 8'h01, 1'b1, 1'b1);
      t_sub(8'h30, 8'h2f, 1'b0, 1'b0);
      t_dec(2'h1, 8'h01);
      t_dec(2'h1, 8'h00);
      t_dec(2'h2, 8'h01);
      t_dec(2'h2, 8'h02);
      t_refuse();
      give_verdict();
   end
endmodule
